// ---- logic/dpcp_dev.sv ----
// potentiometer command port: link slave and wiper state
`timescale 1ns/10ps
module dpcp_dev #(
  parameter int  LOCK_CYC = dpcp_pkg::LOCK_CYC,
  parameter bit  TAPS_256 = 1'b1
) (
  input  wire logic            mclk_i,
  input  wire logic            rstn_i,
  dpcp_link_if.dev             link,
  input  wire logic            hw_reset_n_i,
  input  wire logic [1:0]      slave_addr_strap_low_i,
  input  wire logic [1:0]      slave_addr_strap_high_i,
  output logic [1:0][7:0]      wiper_o,
  output logic                 shutdown_o,
  output logic                 busy_o
);
  typedef enum {S_IDLE, S_ADDR, S_WRITE, S_READ} dpcp_dst_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] strap_bits(input logic [1:0] s);
    strap_bits = (s == dpcp_pkg::STRAP_HIGH) ? 2'h0 :
                 (s == dpcp_pkg::STRAP_OPEN) ? 2'h2 : 2'h3;
  endfunction

  function automatic logic [7:0] tap_fix(input logic [7:0] d);
    tap_fix = TAPS_256 ? d : {d[7:1], 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  dpcp_dst_t   st_q;
  logic        start_tgl_q;
  logic        start_seen_q;
  logic [3:0]  bcnt_q;
  logic [7:0]  sh_q;
  logic        hi_done_q;
  logic [7:0]  hi_byte_q;
  logic [15:0] cmd_word_q;
  logic        cmd_tgl_q;
  logic        busy_m_q;
  logic        busy_l_q;
  logic [1:0]  sl_m_q;
  logic [1:0]  sl_s_q;
  logic [1:0]  sh_m_q;
  logic [1:0]  sh_s_q;
  logic [6:0]  my_addr;
  logic        addr_hit;
  logic [7:0]  rb_q;

  // start: sda falls while scl high; seen at the next scl rise,
  // a full scl period later, so it has long settled
  always_ff @(negedge link.sda or negedge rstn_i) begin
    if (!rstn_i) begin
      start_tgl_q <= 1'b0;
    end else if (link.scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(posedge link.scl or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_m_q <= 1'b1;
      busy_l_q <= 1'b1;
      sl_m_q   <= 2'h0;
      sl_s_q   <= 2'h0;
      sh_m_q   <= 2'h0;
      sh_s_q   <= 2'h0;
    end else begin
      busy_m_q <= busy_o;
      busy_l_q <= busy_m_q;
      sl_m_q   <= slave_addr_strap_low_i;
      sl_s_q   <= sl_m_q;
      sh_m_q   <= slave_addr_strap_high_i;
      sh_s_q   <= sh_m_q;
    end
  end

  // only the strapped 7-bit address matches; general call never does
  assign my_addr  = {dpcp_pkg::ADDR_BASE, strap_bits(sh_s_q), strap_bits(sl_s_q)};
  assign addr_hit = (sh_q[7:1] == my_addr);

  always_ff @(posedge link.scl or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q         <= S_IDLE;
      start_seen_q <= 1'b0;
      bcnt_q       <= 4'h0;
      sh_q         <= 8'h00;
      hi_done_q    <= 1'b0;
      hi_byte_q    <= 8'h00;
      cmd_word_q   <= 16'h0000;
      cmd_tgl_q    <= 1'b0;
    end else if (start_tgl_q != start_seen_q) begin
      start_seen_q <= start_tgl_q;
      st_q         <= S_ADDR;
      sh_q         <= {7'h00, link.sda};
      bcnt_q       <= 4'h1;
      hi_done_q    <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: bcnt_q <= 4'h0;
        S_ADDR: begin
          if (bcnt_q != 4'h8) begin
            sh_q   <= {sh_q[6:0], link.sda};
            bcnt_q <= bcnt_q + 4'h1;
          end else begin
            bcnt_q <= 4'h0;
            // direction bit picks read or write
            if (addr_hit && !busy_l_q) begin
              st_q <= sh_q[0] ? S_READ : S_WRITE;
            end else begin
              st_q <= S_IDLE;
            end
          end
        end
        S_WRITE: begin
          if (bcnt_q != 4'h8) begin
            sh_q   <= {sh_q[6:0], link.sda}; // msb first
            bcnt_q <= bcnt_q + 4'h1;
          end else begin
            bcnt_q <= 4'h0;
            if (busy_l_q) begin
              st_q <= S_IDLE;
            end else if (!hi_done_q) begin
              hi_byte_q <= sh_q;
              hi_done_q <= 1'b1;
            end else begin
              // code, select, data
              cmd_word_q <= {hi_byte_q, sh_q};
              cmd_tgl_q  <= ~cmd_tgl_q;
              hi_done_q  <= 1'b0;
            end
          end
        end
        S_READ: begin
          if (bcnt_q != 4'h8) begin
            bcnt_q <= bcnt_q + 4'h1;
          end else begin
            bcnt_q <= 4'h0;
            // master nack ends the read
            if (link.sda) begin
              st_q <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // outputs change on the falling edge only
  assign link.sda_dev_o = 1'b0;

  always_ff @(negedge link.scl or negedge rstn_i) begin
    if (!rstn_i) begin
      link.sda_dev_oe <= 1'b0;
    end else begin
      unique case (st_q)
        S_ADDR:  link.sda_dev_oe <= (bcnt_q == 4'h8) && addr_hit && !busy_l_q;
        S_WRITE: link.sda_dev_oe <= (bcnt_q == 4'h8) && !busy_l_q;
        S_READ:  link.sda_dev_oe <= (bcnt_q != 4'h8) && !rb_q[3'(4'h7 - bcnt_q)];
        S_IDLE:  link.sda_dev_oe <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------
  logic        cmd_m_q;
  logic        cmd_s_q;
  logic        cmd_p_q;
  logic        cmd_go;
  logic        rst_m_q;
  logic        rst_s_q;
  logic [3:0]  code;
  logic [3:0]  sel;
  logic [7:0]  data;
  logic [17:0] lock_q;
  logic [8:0]  reload_q;
  logic        reload_end;
  logic [1:0][7:0] pre_q;
  logic [1:0][7:0] nvm_q;
  logic        rb_ch;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_m_q <= 1'b0;
      cmd_s_q <= 1'b0;
      cmd_p_q <= 1'b0;
      rst_m_q <= 1'b1;
      rst_s_q <= 1'b1;
    end else begin
      cmd_m_q <= cmd_tgl_q;
      cmd_s_q <= cmd_m_q;
      cmd_p_q <= cmd_s_q;
      rst_m_q <= hw_reset_n_i;
      rst_s_q <= rst_m_q;
    end
  end

  // word is held stable in the link domain until the next one
  assign cmd_go     = (cmd_s_q != cmd_p_q) && !busy_o;
  assign code       = cmd_word_q[dpcp_pkg::CMD_LSB +: 4];
  assign sel        = cmd_word_q[dpcp_pkg::SEL_LSB +: 4];
  assign data       = cmd_word_q[dpcp_pkg::DATA_W-1:0];
  assign reload_end = (reload_q == 9'h001);
  assign busy_o     = (lock_q != 18'h0) || (reload_q != 9'h000);
  assign rb_ch      = sel[1] | sel[0];

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q <= 18'h0;
    end else if (cmd_go && (code == dpcp_pkg::CMD_NVM_WR ||
                            (code == dpcp_pkg::CMD_COPY && data[0]))) begin
      lock_q <= 18'(LOCK_CYC);
    end else if (lock_q != 18'h0) begin
      lock_q <= lock_q - 18'h1;
    end
  end

  // power-up starts with a reload
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reload_q <= 9'(dpcp_pkg::RELOAD_CYC);
    end else if (!rst_s_q || (cmd_go && code == dpcp_pkg::CMD_SW_RESET)) begin
      reload_q <= 9'(dpcp_pkg::RELOAD_CYC);
    end else if (reload_q != 9'h000) begin
      reload_q <= reload_q - 9'h001;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shutdown_o <= 1'b0;
    end else if (cmd_go && code == dpcp_pkg::CMD_SHUTDOWN) begin
      shutdown_o <= data[0];
    end
  end

  generate
    for (genvar ch = 0; ch < dpcp_pkg::NUM_CH; ch++) begin : g_ch
      logic hit;
      logic mem_hit;
      // top select bit reaches every channel
      assign hit = cmd_go && (sel[dpcp_pkg::SEL_ALL] || sel[0] == 1'(ch));
      // memory slots decode apart: 0010 names the second slot
      assign mem_hit = cmd_go && (sel[dpcp_pkg::SEL_ALL] || rb_ch == 1'(ch));

      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          wiper_o[ch] <= dpcp_pkg::MIDSCALE;
        end else if (reload_end) begin
          wiper_o[ch] <= nvm_q[ch];
        end else if (hit && code == dpcp_pkg::CMD_WIPER_WR) begin
          wiper_o[ch] <= tap_fix(data);
        end else if (hit && code == dpcp_pkg::CMD_COPY && !data[0]) begin
          wiper_o[ch] <= nvm_q[ch];
        end
      end

      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pre_q[ch] <= dpcp_pkg::MIDSCALE;
        end else if (hit && code == dpcp_pkg::CMD_PRE_WR) begin
          pre_q[ch] <= data;
        end else if (hit && code == dpcp_pkg::CMD_WIPER_WR) begin
          pre_q[ch] <= tap_fix(data);
        end
      end

      // flops stand in for the cells; they hold midscale after power-up
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          nvm_q[ch] <= dpcp_pkg::MIDSCALE;
        end else if (mem_hit && code == dpcp_pkg::CMD_COPY && data[0]) begin
          nvm_q[ch] <= wiper_o[ch];
        end else if (mem_hit && code == dpcp_pkg::CMD_NVM_WR) begin
          nvm_q[ch] <= tap_fix(data);
        end
      end
    end
  endgenerate

  // other codes, nop included, fall through untouched
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rb_q <= 8'h00;
    end else if (cmd_go && code == dpcp_pkg::CMD_READ) begin
      unique case (data[1:0])
        dpcp_pkg::RB_NVM:     rb_q <= tap_fix(nvm_q[rb_ch]);
        dpcp_pkg::RB_WIPER:   rb_q <= tap_fix(wiper_o[rb_ch]);
        dpcp_pkg::RB_PRELOAD: rb_q <= pre_q[rb_ch];
        default:              rb_q <= 8'h00;
      endcase
    end
  end
endmodule

// ---- logic/dpcp_pkg.sv ----
// constants shared by both ends of the dual pot command port
package dpcp_pkg;
  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int MCLK_KHZ    = 10000;
  localparam int SCL_KHZ     = 100;
  localparam int SCL_QTR_CYC = MCLK_KHZ / (4 * SCL_KHZ);
  localparam int LOCK_MS     = 15;
  localparam int LOCK_CYC    = LOCK_MS * MCLK_KHZ;
  localparam int RELOAD_US   = 30;
  localparam int RELOAD_CYC  = (RELOAD_US * MCLK_KHZ) / 1000;

  // ----------------------------------------------------------------
  // command word layout
  // ----------------------------------------------------------------
  localparam int WORD_W   = 16;
  localparam int CMD_LSB  = 12;
  localparam int SEL_LSB  = 8;
  localparam int DATA_W   = 8;
  localparam int SEL_ALL  = 3;
  localparam int NUM_CH   = 2;

  localparam logic [3:0] CMD_NOP      = 4'h0;
  localparam logic [3:0] CMD_WIPER_WR = 4'h1;
  localparam logic [3:0] CMD_PRE_WR   = 4'h2;
  localparam logic [3:0] CMD_READ     = 4'h3;
  localparam logic [3:0] CMD_NVM_WR   = 4'h6;
  localparam logic [3:0] CMD_COPY     = 4'h7;
  localparam logic [3:0] CMD_SW_RESET = 4'hb;
  localparam logic [3:0] CMD_SHUTDOWN = 4'hc;

  localparam logic [1:0] RB_PRELOAD = 2'h0;
  localparam logic [1:0] RB_NVM     = 2'h1;
  localparam logic [1:0] RB_WIPER   = 2'h3;

  localparam logic [7:0] MIDSCALE = 8'h80;

  // ----------------------------------------------------------------
  // slave address straps
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_OPEN = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_GND  = 2'h2;
  localparam logic [2:0] ADDR_BASE  = 3'h2;
endpackage

// ---- logic/dpcp_link_if.sv ----
// two-wire link between command port master and potentiometer
`timescale 1ns/10ps
interface dpcp_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // open drain with pull-up: any enabled low driver wins
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport dev (
    input  scl,
    input  sda,
    output sda_dev_o,
    output sda_dev_oe
  );

  modport host (
    input  sda,
    output scl_o,
    output scl_oe,
    output sda_host_o,
    output sda_host_oe
  );
endinterface

// ---- logic/dpcp_host.sv ----
// two-wire master issuing command words and read transfers
`timescale 1ns/10ps
module dpcp_host (
  input  wire logic           mclk_i,
  input  wire logic           rstn_i,
  dpcp_link_if.host           link,
  input  wire logic           req_valid_i,
  output logic                req_ready_o,
  input  wire logic           req_read_i,
  input  wire logic [15:0]    req_word_i,
  input  wire logic [6:0]     dev_addr_i,
  output logic                done_o,
  output logic                done_nack_o,
  output logic [7:0]          rd_data_o
);
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} dpcp_hst_t;

  dpcp_hst_t   st_q;
  logic [7:0]  div_q;
  logic        tick;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q;
  logic [1:0]  nbytes_q;
  logic [8:0]  tx_q;
  logic [8:0]  rx_q;
  logic [15:0] word_q;
  logic [7:0]  addr_byte_q;
  logic        rd_q;
  logic        nack_q;
  logic        sda_m_q;
  logic        sda_s_q;

  // ----------------------------------------------------------------
  // divider and input sync
  // ----------------------------------------------------------------
  assign tick = (div_q == 8'(dpcp_pkg::SCL_QTR_CYC - 1));

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= 8'h00;
    end else if (tick || st_q == H_IDLE) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
    end
  end

  assign req_ready_o      = (st_q == H_IDLE);
  assign link.scl_o       = 1'b0;
  assign link.sda_host_o  = 1'b0;

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q             <= H_IDLE;
      ph_q             <= 2'h0;
      bit_q            <= 4'h0;
      byte_q           <= 2'h0;
      nbytes_q         <= 2'h0;
      tx_q             <= 9'h1ff;
      rx_q             <= 9'h000;
      word_q           <= 16'h0000;
      addr_byte_q      <= 8'h00;
      rd_q             <= 1'b0;
      nack_q           <= 1'b0;
      link.scl_oe      <= 1'b0;
      link.sda_host_oe <= 1'b0;
      done_o           <= 1'b0;
      done_nack_o      <= 1'b0;
      rd_data_o        <= 8'h00;
    end else begin
      done_o <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (req_valid_i) begin
            st_q        <= H_START;
            ph_q        <= 2'h0;
            word_q      <= req_word_i;
            rd_q        <= req_read_i;
            // address first, then the word high byte first
            addr_byte_q <= {dev_addr_i, req_read_i};
            nbytes_q    <= req_read_i ? 2'h1 : 2'h2;
            nack_q      <= 1'b0;
          end
        end
        H_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            // sda falls while scl is high
            if (ph_q == 2'h1) begin
              link.sda_host_oe <= 1'b1;
            end
            if (ph_q == 2'h2) begin
              link.scl_oe <= 1'b1;
            end
            if (ph_q == 2'h3) begin
              st_q   <= H_BIT;
              bit_q  <= 4'h0;
              byte_q <= 2'h0;
              tx_q   <= {addr_byte_q, 1'b1};
            end
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              // sda only moves while scl is low
              2'h0: link.sda_host_oe <= ~tx_q[8];
              2'h1: link.scl_oe      <= 1'b0;
              2'h2: rx_q             <= {rx_q[7:0], sda_s_q};
              2'h3: begin
                link.scl_oe <= 1'b1;
                tx_q        <= {tx_q[7:0], 1'b1};
                bit_q       <= bit_q + 4'h1;
                // nine clocks per byte
                if (bit_q == 4'h8) begin
                  bit_q  <= 4'h0;
                  byte_q <= byte_q + 2'h1;
                  if (!(rd_q && byte_q == 2'h1) && rx_q[0]) begin
                    nack_q <= 1'b1;
                    st_q   <= H_STOP;
                  end else if (byte_q == nbytes_q) begin
                    st_q <= H_STOP;
                  end else if (rd_q) begin
                    // released data, final byte not acknowledged
                    tx_q <= 9'h1ff;
                  end else if (byte_q == 2'h0) begin
                    tx_q <= {word_q[15:8], 1'b1}; // msb first
                  end else begin
                    tx_q <= {word_q[7:0], 1'b1};
                  end
                  if (rd_q && byte_q == 2'h1) begin
                    rd_data_o <= rx_q[8:1];
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            // sda low, scl up, then sda rises
            if (ph_q == 2'h0) begin
              link.sda_host_oe <= 1'b1;
            end
            if (ph_q == 2'h1) begin
              link.scl_oe <= 1'b0;
            end
            if (ph_q == 2'h2) begin
              link.sda_host_oe <= 1'b0;
            end
            if (ph_q == 2'h3) begin
              st_q        <= H_IDLE;
              done_o      <= 1'b1;
              done_nack_o <= nack_q;
            end
          end
        end
      endcase
    end
  end
endmodule

// ---- sim/dpcp_link_checker.sv ----
// wire-level checker for the dual pot command link
`timescale 1ns/10ps
module dpcp_link_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  // ----------------------------------------------------------------
  // link tracking
  // ----------------------------------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic       rd_q;
  logic       fr_q;
  logic [4:0] cnt_q;
  logic       hi;
  logic       start;
  logic       stop;
  assign hi    = scl & scl_q;
  assign start = hi & sda_q & ~sda;
  assign stop  = hi & ~sda_q & sda;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // scl rises counted per frame; direction taken at the eighth
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd_q  <= 1'b0;
      fr_q  <= 1'b0;
      cnt_q <= 5'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        fr_q  <= 1'b1;
        rd_q  <= 1'b0;
        cnt_q <= 5'h00;
      end else if (scl & ~scl_q) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'h07) begin
          rd_q <= sda;
        end
      end
      if (stop) begin
        fr_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  dev_sda_edge_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device sda moved while scl high");
  write_ack_slot_a: assert property (sda_dev_oe && hi && !rd_q |-> cnt_q inside {5'h09, 5'h12, 5'h1b})
    else $error("device drove sda outside an ack slot");
  read_drive_a: assert property (sda_dev_oe && hi && rd_q |-> cnt_q >= 5'h09 && cnt_q <= 5'h11)
    else $error("device drove sda outside its read byte");
  master_nack_a: assert property (rd_q && hi && cnt_q == 5'h12 |-> sda)
    else $error("read byte was acknowledged");
  stop_count_a: assert property (stop |-> cnt_q inside {5'h0a, 5'h13, 5'h1c})
    else $error("stop after a partial byte");
  scl_in_frame_a: assert property (!scl |-> fr_q)
    else $error("scl low outside a frame");
  dev_idle_a: assert property (!fr_q |-> !sda_dev_oe)
    else $error("device drove sda outside a frame");
  scl_low_span_a: assert property ($fell(scl) |-> ##[40:90] scl)
    else $error("scl low period out of range");
  host_sda_edge_a: assert property ($changed(sda_host_oe) && hi |-> start || stop)
    else $error("host sda moved while scl high");
  cover property (stop && cnt_q == 5'h1c);
  cover property (stop && cnt_q == 5'h13);
  cover property (stop && cnt_q == 5'h0a);
endmodule

// ---- sim/dpcp_tb.sv ----
// self-checking bench for the dual pot command port
`timescale 1ns/10ps
module i2c_dual_pot_command_port_tb;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic            mclk_i       = 1'b0;
  logic            rstn_i       = 1'b0;
  logic            hw_reset_n_i = 1'b1;
  logic            req_valid_i  = 1'b0;
  logic            req_read_i   = 1'b0;
  logic [15:0]     req_word_i   = 16'h0000;
  logic [6:0]      dev_addr_i   = 7'h20;
  logic [1:0]      strap_lo     = dpcp_pkg::STRAP_HIGH;
  logic [1:0]      strap_hi     = dpcp_pkg::STRAP_HIGH;
  logic            req_ready_o;
  logic            done_o;
  logic            done_nack_o;
  logic            shutdown_o;
  logic            busy_o;
  logic [7:0]      rd_data_o;
  logic [1:0][7:0] wiper_o;
  int              fail_count   = 0;
  int              comparisons  = 0;
  localparam logic [5:0]  LVL = {dpcp_pkg::STRAP_GND, dpcp_pkg::STRAP_OPEN, dpcp_pkg::STRAP_HIGH};
  localparam logic [20:0] ADR = {7'h2f, 7'h2a, 7'h20};
  localparam logic [15:0] ODD = {4'he, 4'h8, 4'h4, 4'h0};
  dpcp_link_if link ();
  dpcp_host u_dpcp_host (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_read_i(req_read_i),
    .req_word_i(req_word_i), .dev_addr_i(dev_addr_i), .done_o(done_o),
    .done_nack_o(done_nack_o), .rd_data_o(rd_data_o));
  // lock shortened so a store outlasts the next transfer but not one idle wait
  dpcp_dev #(.LOCK_CYC(2000)) u_dpcp_dev (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link),
    .hw_reset_n_i(hw_reset_n_i), .slave_addr_strap_low_i(strap_lo),
    .slave_addr_strap_high_i(strap_hi), .wiper_o(wiper_o), .shutdown_o(shutdown_o), .busy_o(busy_o));
  dpcp_link_checker u_dpcp_link_checker (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl(link.scl),
    .sda(link.sda), .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe));
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic rd, input logic [15:0] w);
    int n;
    n = 0;
    @(negedge mclk_i);
    req_read_i = rd;
    req_word_i = w;
    req_valid_i = 1'b1;
    // ready looked at off the edge; the next rise takes the request
    while (req_ready_o !== 1'b1) @(negedge mclk_i);
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    check({15'h0, done_o}, 16'h0001);
  endtask
  task automatic wr(input logic [15:0] w, input logic nack);
    xfer(1'b0, w);
    check({15'h0, done_nack_o}, {15'h0, nack});
  endtask
  task automatic rd(input logic [3:0] sel, input logic [7:0] d, input logic [7:0] exp);
    wr({dpcp_pkg::CMD_READ, sel, d}, 1'b0);
    xfer(1'b1, 16'h0000);
    check({8'h0, rd_data_o}, {8'h0, exp});
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 5000) begin
      @(negedge mclk_i);
      n++;
    end
    check({15'h0, busy_o}, 16'h0000);
    // link side sees busy late; a throwaway read clocks the stale busy samples out of the scl-side sync
    xfer(1'b1, 16'h0000);
  endtask
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (99000) @(posedge mclk_i);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge mclk_i);
    rstn_i = 1'b1;
    check({15'h0, busy_o}, 16'h0001);
    idle();
    check(wiper_o, 16'h8080);
    for (int i = 0; i < 3; i++) begin
      strap_lo = LVL[2*i+:2];
      strap_hi = LVL[2*i+:2];
      dev_addr_i = ADR[7*i+:7];
      wr(16'h0000, 1'b0);
    end
    dev_addr_i = 7'h2e;
    wr(16'h0000, 1'b1);
    dev_addr_i = 7'h00;
    wr(16'h0000, 1'b1);
    dev_addr_i = 7'h2f;
    wr({dpcp_pkg::CMD_WIPER_WR, 4'h0, 8'h3c}, 1'b0);
    wr({dpcp_pkg::CMD_WIPER_WR, 4'h1, 8'hc5}, 1'b0);
    check(wiper_o, 16'hc53c);
    rd(4'h0, 8'h03, 8'h3c);
    rd(4'h1, 8'h03, 8'hc5);
    wr({dpcp_pkg::CMD_PRE_WR, 4'h1, 8'h5a}, 1'b0);
    check(wiper_o, 16'hc53c);
    rd(4'h1, 8'h00, 8'h5a);
    wr({dpcp_pkg::CMD_WIPER_WR, 4'h8, 8'h11}, 1'b0);
    check(wiper_o, 16'h1111);
    wr({dpcp_pkg::CMD_COPY, 4'h0, 8'h01}, 1'b0);
    check({15'h0, busy_o}, 16'h0001);
    wr({dpcp_pkg::CMD_WIPER_WR, 4'h0, 8'h77}, 1'b1);
    check(wiper_o, 16'h1111);
    idle();
    wr({dpcp_pkg::CMD_WIPER_WR, 4'h0, 8'h77}, 1'b0);
    wr({dpcp_pkg::CMD_COPY, 4'h0, 8'h00}, 1'b0);
    idle();
    check(wiper_o, 16'h1111);
    rd(4'h0, 8'h01, 8'h11);
    wr({dpcp_pkg::CMD_NVM_WR, 4'h2, 8'h99}, 1'b0);
    idle();
    wr({dpcp_pkg::CMD_WIPER_WR, 4'h0, 8'h44}, 1'b0);
    check(wiper_o, 16'h1144);
    wr({dpcp_pkg::CMD_SW_RESET, 4'h0, 8'h00}, 1'b0);
    check({15'h0, busy_o}, 16'h0001);
    idle();
    check(wiper_o, 16'h9911);
    wr({dpcp_pkg::CMD_SHUTDOWN, 4'h0, 8'h01}, 1'b0);
    check({15'h0, shutdown_o}, 16'h0001);
    wr({dpcp_pkg::CMD_WIPER_WR, 4'h0, 8'h42}, 1'b0);
    check(wiper_o, 16'h9942);
    wr({dpcp_pkg::CMD_SHUTDOWN, 4'h0, 8'h00}, 1'b0);
    check({15'h0, shutdown_o}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr({ODD[4*i+:4], 4'h0, 8'hff}, 1'b0);
      check(wiper_o, 16'h9942);
    end
    hw_reset_n_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    hw_reset_n_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    check({15'h0, busy_o}, 16'h0001);
    idle();
    check(wiper_o, 16'h9911);
    summarize();
  end
endmodule
